/* File: rtl/tfl_tx_framer.sv */
// Purpose: T1/J1 transmit frame generator with inband loopback code generator.
// Assumes: One line bit per enabled clock; payload bytes supplied for chan_index_o.
// Notes: Mode, format and loopback settings take effect at the next frame bit.
//
// Notes on behaviour
// - In EXTENDED_SUPERFRAME_SELECT, frame check uses T1 variant when crc bit is 0, J1 when 1.
// - T1 yellow in SF forces the second bit of every channel to zero.
// - T1 yellow in EXTENDED_SUPERFRAME_SELECT repeats FF00 on the data link.
// - J1 yellow in SF drives the twelfth framing bit to one.
// - J1 yellow in EXTENDED_SUPERFRAME_SELECT repeats FFFF on the data link.
// - Format bit 0 builds SF frames, 1 builds EXTENDED_SUPERFRAME_SELECT; also picks yellow pattern.
// - Global and per-channel suppression selects are ORed per channel.
// - Code 01: all-zero channel gets bit 8 set, bit 7 in signaling frames.
// - Code 11 sets bit 7 of all-zero channel; 00 none; 10 reserved.
// - Manual yellow bit 1 sends the selected yellow pattern, 0 sends none.
// - Loopback code starts and stops at the first framing bit after its enable bit changes.
// - Framed loopback replaces the 192 payload bits, framing bit kept.
// - Unframed loopback replaces all 193 bits, framing bit included.
// - Length field 00/01/10/11 gives 5/6/7/8 code bits from bit 7 down.
// - Code register bit 7 is the pattern's most significant bit.
`timescale 1ns/1ps
`include "tfl_regs.svh"

module tfl_tx_framer import tfl_pkg::*; #(
   parameter int AW = `TFL_ADDR_W
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic [AW-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [7:0] payload_byte_i,
   input wire logic [1:0] channel_zero_suppress_select_i,
   input wire logic fdl_bit_i,
   output logic [4:0] chan_index_o,
   output logic fdl_take_o,
   output logic line_bit_o,
   output logic fbit_slot_o,
   output logic superframe_start_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.

   tfl_byte_t frame_generator_config;
   tfl_byte_t frame_generator_alarm_transmit;
   tfl_byte_t loopback_code_gen_control;
   tfl_byte_t loopback_code_pattern;

   logic japan_crc_variant_select;
   logic japan_yellow_style_select;
   logic extended_superframe_select;
   logic [1:0] global_zero_suppress_select;
   logic manual_yellow_alarm_enable;
   logic loopback_enable;
   logic unframed_loopback_select;
   logic [1:0] loopback_code_length;

   assign japan_crc_variant_select = frame_generator_config[`TFL_CFG_CRC_BIT];
   assign japan_yellow_style_select = frame_generator_config[`TFL_CFG_YEL_BIT];
   assign extended_superframe_select = frame_generator_config[`TFL_CFG_ESF_BIT];
   assign global_zero_suppress_select =
      frame_generator_config[`TFL_CFG_GLOBAL_ZERO_SUPPRESS_SELECT_HI:`TFL_CFG_GLOBAL_ZERO_SUPPRESS_SELECT_LO];
   assign manual_yellow_alarm_enable = frame_generator_alarm_transmit[`TFL_ALARM_YEL_BIT];
   assign loopback_enable = loopback_code_gen_control[`TFL_LB_EN_BIT];
   assign unframed_loopback_select = loopback_code_gen_control[`TFL_LB_UF_BIT];
   assign loopback_code_length = loopback_code_gen_control[`TFL_LB_CL_HI:`TFL_LB_CL_LO];

   // Unused bits other than config bit 7 are masked on write so they always read zero.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         frame_generator_config <= `TFL_CFG_RESET;
         frame_generator_alarm_transmit <= `TFL_ALARM_RESET;
         loopback_code_gen_control <= `TFL_LB_CTL_RESET;
         loopback_code_pattern <= `TFL_LB_CODE_RESET;
      end else if (ce_i && reg_wr_i) begin
         unique case (reg_addr_i)
            `TFL_ADDR_CFG: begin
               frame_generator_config <= reg_wdata_i & `TFL_CFG_WMASK;
            end
            `TFL_ADDR_ALARM: begin
               frame_generator_alarm_transmit <= reg_wdata_i & `TFL_ALARM_WMASK;
            end
            `TFL_ADDR_LB_CTL: begin
               loopback_code_gen_control <= reg_wdata_i & `TFL_LB_CTL_WMASK;
            end
            `TFL_ADDR_LB_CODE: begin
               loopback_code_pattern <= reg_wdata_i;
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Frame position state.

   logic [7:0] bit_pos;
   logic [2:0] bit_cnt;
   logic [4:0] chan_cnt;
   logic [4:0] frame_cnt;
   tfl_mode_e mode;
   tfl_mode_e req_mode;
   tfl_byte_t chan_reg;
   logic [2:0] lb_ptr;
   logic [15:0] yel_sr;
   logic [5:0] crc_hold;
   logic [5:0] crc_now;

   logic fslot;
   logic last_frame;
   logic [4:0] frame_last;
   logic yellow;
   logic sig_frame;
   logic load_chan;
   logic code_bit;
   logic use_code;
   logic dl_slot;
   logic next_bit;
   logic crc_feed;
   logic [2:0] code_last;
   logic [2:0] quad;

   assign fslot = (bit_pos == 8'h00);
   assign yellow = manual_yellow_alarm_enable;
   assign frame_last = extended_superframe_select ? `TFL_ESF_LAST_FRAME
                                                  : `TFL_SF_LAST_FRAME;
   assign last_frame = (frame_cnt >= frame_last);
   assign quad = frame_cnt[4:2];
   // Signaling frames are 6 and 12 (SF) or every sixth frame (EXTENDED_SUPERFRAME_SELECT).
   assign sig_frame = (frame_cnt == 5'h05) || (frame_cnt == 5'h0B) ||
                      (frame_cnt == 5'h11) || (frame_cnt == 5'h17);
   assign load_chan = fslot || ((bit_cnt == `TFL_LAST_BIT) && (chan_cnt != `TFL_LAST_CHAN));
   assign code_last = `TFL_LB_MIN_LAST + {1'b0, loopback_code_length};
   assign code_bit = loopback_code_pattern[3'h7 - lb_ptr];

   always_comb begin
      if (!loopback_enable) begin
         req_mode = TFL_MODE_NORMAL;
      end else if (unframed_loopback_select) begin
         req_mode = TFL_MODE_UNFRAMED;
      end else begin
         req_mode = TFL_MODE_FRAMED;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Channel shaping: zero code suppression and the SF yellow bit.

   function automatic tfl_byte_t tfl_shape(input tfl_byte_t b, input logic [1:0] channel_zero_suppress_select,
                                           input logic sig, input logic yel_sf);
      tfl_byte_t r;
      r = b;
      if (b == 8'h00) begin
         unique case (channel_zero_suppress_select)
            2'b01: begin
               if (sig) begin
                  r[1] = 1'b1;
               end else begin
                  r[0] = 1'b1;
               end
            end
            2'b11: begin
               r[1] = 1'b1;
            end
            default: begin
               r = b;
            end
         endcase
      end
      if (yel_sf) begin
         r[6] = 1'b0;
      end
      return r;
   endfunction : tfl_shape

   ////////////////////////////////////////////////////////////////////////////////
   // Next line bit.

   always_comb begin
      use_code = 1'b0;
      dl_slot = 1'b0;
      next_bit = 1'b0;
      crc_feed = 1'b0;
      if (fslot) begin
         if (req_mode == TFL_MODE_UNFRAMED) begin
            use_code = 1'b1;
            next_bit = code_bit;
         end else if (extended_superframe_select) begin
            unique case (frame_cnt[1:0])
               2'b11: begin
                  next_bit = 1'(`TFL_ESF_FAS >> (3'h5 - quad));
               end
               2'b01: begin
                  next_bit = crc_hold[3'h5 - quad];
               end
               default: begin
                  dl_slot = 1'b1;
                  if (yellow && japan_yellow_style_select) begin
                     next_bit = 1'b1;
                  end else if (yellow) begin
                     next_bit = yel_sr[15];
                  end else begin
                     next_bit = fdl_bit_i;
                  end
               end
            endcase
         end else if (yellow && japan_yellow_style_select
                      && (frame_cnt == `TFL_SF_LAST_FRAME)) begin
            next_bit = 1'b1;
         end else begin
            next_bit = 1'(`TFL_SF_FAS >> (5'h0B - frame_cnt));
         end
         // The T1 check sees every framing bit as one; the J1 check sees it as sent.
         crc_feed = japan_crc_variant_select ? next_bit : 1'b1;
      end else if (mode != TFL_MODE_NORMAL) begin
         use_code = 1'b1;
         next_bit = code_bit;
         crc_feed = next_bit;
      end else begin
         next_bit = chan_reg[3'h7 - bit_cnt];
         crc_feed = next_bit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Position counters and mode.

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         bit_pos <= 8'h00;
         bit_cnt <= 3'h0;
         chan_cnt <= 5'h00;
      end else if (ce_i) begin
         if (bit_pos == `TFL_LAST_POS) begin
            bit_pos <= 8'h00;
         end else begin
            bit_pos <= bit_pos + 8'h01;
         end
         if (fslot) begin
            bit_cnt <= 3'h0;
            chan_cnt <= 5'h00;
         end else begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == `TFL_LAST_BIT) begin
               chan_cnt <= chan_cnt + 5'h01;
            end
         end
      end
   end

   // Format changes land on a frame boundary; a shorter superframe wraps at once.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         frame_cnt <= 5'h00;
      end else if (ce_i && (bit_pos == `TFL_LAST_POS)) begin
         frame_cnt <= last_frame ? 5'h00 : frame_cnt + 5'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         mode <= TFL_MODE_NORMAL;
      end else if (ce_i && fslot) begin
         mode <= req_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Channel byte load.

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         chan_reg <= 8'h00;
         chan_index_o <= 5'h00;
      end else if (ce_i && load_chan) begin
         chan_reg <= tfl_shape(payload_byte_i,
                               global_zero_suppress_select | channel_zero_suppress_select_i,
                               sig_frame,
                               yellow && !japan_yellow_style_select
                               && !extended_superframe_select);
         if (fslot) begin
            chan_index_o <= 5'h01;
         end else if (chan_cnt == 5'h16) begin
            chan_index_o <= 5'h00;
         end else begin
            chan_index_o <= chan_cnt + 5'h02;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Loopback code pointer and yellow data link pattern.

   // The pointer runs on across frames so the pattern has no seams.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         lb_ptr <= 3'h0;
      end else if (ce_i) begin
         if (!loopback_enable) begin
            lb_ptr <= 3'h0;
         end else if (use_code) begin
            lb_ptr <= (lb_ptr >= code_last) ? 3'h0 : lb_ptr + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         yel_sr <= `TFL_YEL_T1_FDL;
      end else if (ce_i) begin
         if (!yellow) begin
            yel_sr <= `TFL_YEL_T1_FDL;
         end else if (dl_slot) begin
            yel_sr <= {yel_sr[14:0], yel_sr[15]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Frame check over each extended superframe.

   tfl_crc6 #(
      .WIDTH(6),
      .POLY(`TFL_CRC_POLY)
   ) u_crc (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .start_i(fslot && (frame_cnt == 5'h00)),
      .bit_valid_i(1'b1),
      .bit_i(crc_feed),
      .crc_o(crc_now)
   );

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         crc_hold <= 6'h00;
      end else if (ce_i && fslot && (frame_cnt == 5'h00)) begin
         crc_hold <= crc_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Line outputs.

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         line_bit_o <= 1'b0;
         fbit_slot_o <= 1'b0;
         superframe_start_o <= 1'b0;
         fdl_take_o <= 1'b0;
      end else if (ce_i) begin
         line_bit_o <= next_bit;
         fbit_slot_o <= fslot;
         superframe_start_o <= fslot && (frame_cnt == 5'h00);
         fdl_take_o <= dl_slot && !yellow;
      end else begin
         fdl_take_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register read port.

   // Read data stand for one cycle only; an unmapped address reads zero.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= 8'h00;
      end else if (ce_i && reg_rd_i) begin
         unique case (reg_addr_i)
            `TFL_ADDR_CFG: reg_rdata_o <= frame_generator_config;
            `TFL_ADDR_ALARM: reg_rdata_o <= frame_generator_alarm_transmit;
            `TFL_ADDR_LB_CTL: reg_rdata_o <= loopback_code_gen_control;
            `TFL_ADDR_LB_CODE: reg_rdata_o <= loopback_code_pattern;
            `TFL_ADDR_STATUS: reg_rdata_o <= {mode != TFL_MODE_NORMAL, yellow, 1'b0, frame_cnt};
            default: reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

endmodule : tfl_tx_framer

/* File: rtl/tfl_regs.svh */
// Purpose: Register offsets, field positions, reset values and frame constants of the framer.
// Assumes: Byte-wide registers on an 8-bit address port.
// Notes: Definitions only.
`ifndef TFL_REGS_SVH
`define TFL_REGS_SVH

`define TFL_ADDR_W 8
`define TFL_ADDR_CFG 8'h44
`define TFL_ADDR_ALARM 8'h45
`define TFL_ADDR_LB_CTL 8'h46
`define TFL_ADDR_LB_CODE 8'h47
`define TFL_ADDR_STATUS 8'h48

`define TFL_CFG_RESET 8'h00
`define TFL_ALARM_RESET 8'h00
`define TFL_LB_CTL_RESET 8'h00
`define TFL_LB_CODE_RESET 8'h00

`define TFL_CFG_WMASK 8'hF3
`define TFL_ALARM_WMASK 8'h20
`define TFL_LB_CTL_WMASK 8'hC3

`define TFL_CFG_CRC_BIT 6
`define TFL_CFG_YEL_BIT 5
`define TFL_CFG_ESF_BIT 4
`define TFL_CFG_GLOBAL_ZERO_SUPPRESS_SELECT_HI 1
`define TFL_CFG_GLOBAL_ZERO_SUPPRESS_SELECT_LO 0
`define TFL_ALARM_YEL_BIT 5
`define TFL_LB_EN_BIT 7
`define TFL_LB_UF_BIT 6
`define TFL_LB_CL_HI 1
`define TFL_LB_CL_LO 0

`define TFL_LAST_POS 8'hC0
`define TFL_LAST_BIT 3'h7
`define TFL_LAST_CHAN 5'h17
`define TFL_SF_LAST_FRAME 5'h0B
`define TFL_ESF_LAST_FRAME 5'h17
`define TFL_SF_FAS 12'h8DC
`define TFL_ESF_FAS 6'h0B
`define TFL_YEL_T1_FDL 16'hFF00
`define TFL_YEL_J1_FDL 16'hFFFF
`define TFL_CRC_POLY 6'h03
`define TFL_LB_MIN_LAST 3'h4

`endif

/* File: rtl/tfl_pkg.sv */
// Purpose: Types shared by the transmit framer files.
// Assumes: Nothing beyond the register header.
// Notes: One-hot mode codes.
package tfl_pkg;

   typedef logic [7:0] tfl_byte_t;

   typedef enum logic [2:0] {
      TFL_MODE_NORMAL = 3'b001,
      TFL_MODE_FRAMED = 3'b010,
      TFL_MODE_UNFRAMED = 3'b100
   } tfl_mode_e;

endpackage : tfl_pkg

/* File: rtl/tfl_crc6.sv */
// Purpose: Serial frame check remainder over one extended superframe.
// Assumes: One bit per enabled clock while bit_valid_i is high.
// Notes: start_i restarts the remainder with the current bit as first bit.
`timescale 1ns/1ps
`include "tfl_regs.svh"

module tfl_crc6 import tfl_pkg::*; #(
   parameter int WIDTH = 6,
   parameter logic [WIDTH-1:0] POLY = `TFL_CRC_POLY
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic bit_valid_i,
   input wire logic bit_i,
   output logic [WIDTH-1:0] crc_o
);

   logic [WIDTH-1:0] base;
   logic fb;
   logic [WIDTH-1:0] next_crc;

   always_comb begin
      base = start_i ? '0 : crc_o;
      fb = bit_i ^ base[WIDTH-1];
      next_crc = {base[WIDTH-2:0], 1'b0} ^ (fb ? POLY : '0);
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         crc_o <= '0;
      end else if (ce_i && bit_valid_i) begin
         crc_o <= next_crc;
      end
   end

endmodule : tfl_crc6

/* File: bench/tfl_tx_framer_sva.sv */
// Purpose: Port-level assertions for the transmit framer.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Bound to every framer instance.
`timescale 1ns/1ps
`include "tfl_regs.svh"

module tfl_tx_framer_sva #(
   parameter int AW = 8
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic [AW-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [4:0] chan_index_o,
   input wire logic line_bit_o,
   input wire logic fbit_slot_o,
   input wire logic superframe_start_o
);
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   ////////////////////////////////////////////////////////////////////////////////
   // Slot counter; it only counts enabled cycles, so a clock-enable pause cannot
   // stretch the apparent frame.
   logic [7:0] pos;
   logic seen;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pos <= 8'h00;
         seen <= 1'b0;
      end else if (ce_i) begin
         pos <= fbit_slot_o ? 8'h01 : pos + 8'h01;
         seen <= seen | fbit_slot_o;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   rst_quiet_a: assert property ($rose(resetn_i) |-> !line_bit_o && !fbit_slot_o &&
      chan_index_o == 5'h00 && reg_rdata_o == 8'h00) else $error("outputs not cleared");
   first_frame_a: assert property ($rose(resetn_i) && ce_i |=>
      fbit_slot_o && superframe_start_o && line_bit_o) else $error("no frame 1 start");
   rd_only_a: assert property (reg_rdata_o != 8'h00 |-> $past(reg_rd_i && ce_i))
      else $error("read data without read");
   unmapped_a: assert property (reg_rd_i && ce_i && reg_addr_i > `TFL_ADDR_STATUS |=>
      reg_rdata_o == 8'h00) else $error("unmapped read not zero");
   alarm_mask_a: assert property (reg_wr_i && ce_i && reg_addr_i == `TFL_ADDR_ALARM ##1
      reg_rd_i && ce_i && reg_addr_i == `TFL_ADDR_ALARM |=>
      reg_rdata_o == ($past(reg_wdata_i, 2) & `TFL_ALARM_WMASK)) else $error("alarm readback");
   frame_len_a: assert property (fbit_slot_o && seen |-> pos == 8'd193)
      else $error("frame not 193 slots");
   sf_in_fbit_a: assert property (superframe_start_o |-> fbit_slot_o)
      else $error("superframe start off framing slot");
   ce_freeze_a: assert property (!ce_i |=> $stable(line_bit_o) && $stable(chan_index_o) &&
      $stable(fbit_slot_o)) else $error("state moved with enable low");

   cover property (reg_wr_i && ce_i && reg_addr_i == `TFL_ADDR_LB_CTL && reg_wdata_i[7]);
   cover property (reg_wr_i && ce_i && reg_addr_i == `TFL_ADDR_ALARM && reg_wdata_i[5]);
   cover property (superframe_start_o && ce_i);
endmodule : tfl_tx_framer_sva

bind tfl_tx_framer tfl_tx_framer_sva #(.AW(AW)) u_sva (
   .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .chan_index_o(chan_index_o), .line_bit_o(line_bit_o),
   .fbit_slot_o(fbit_slot_o), .superframe_start_o(superframe_start_o)
);

/* File: bench/tfl_line_side_model.sv */
// Purpose: Line-side partner feeding payload, suppression codes and data link bits.
// Assumes: The bench sets the payload byte and the per-channel code.
// Notes: The data link source toggles on every take so stale bits are visible.
`timescale 1ns/1ps

module tfl_line_side_model (
   input wire logic clk_i,
   input wire logic [7:0] pay_i,
   input wire logic [1:0] zcs_i,
   input wire logic fdl_take_i,
   output logic [7:0] payload_byte_o,
   output logic [1:0] zcs_o,
   output logic fdl_bit_o
);
   assign payload_byte_o = pay_i;
   assign zcs_o = zcs_i;
   initial fdl_bit_o = 1'b0;
   always @(posedge clk_i) begin
      if (fdl_take_i) begin
         fdl_bit_o <= !fdl_bit_o;
      end
   end
endmodule : tfl_line_side_model

/* File: bench/tfl_tx_framer_tb_top.sv */
// Purpose: Self-checking bench for the transmit framer.
// Assumes: Line bits are sampled on the falling edge.
// Notes: Pattern checks accept any phase, since the code pointer runs across frames.
`timescale 1ns/1ps
`include "tfl_regs.svh"

module tfl_tx_framer_tb_top;
   logic clk_i = 0;
   logic resetn_i = 0;
   logic ce_i = 1;
   logic [7:0] reg_addr_i = 0;
   logic [7:0] reg_wdata_i = 0;
   logic reg_wr_i = 0;
   logic reg_rd_i = 0;
   logic [7:0] reg_rdata_o, payload_byte_i, pay = 0;
   logic [1:0] channel_zero_suppress_select_i, channel_zero_suppress_select = 0;
   logic fdl_bit_i, fdl_take_o, line_bit_o, fbit_slot_o, superframe_start_o;
   logic [4:0] chan_index_o;
   logic fr [0:192];
   logic [7:0] msk [4] = '{`TFL_CFG_WMASK, `TFL_ALARM_WMASK, `TFL_LB_CTL_WMASK, 8'hFF};
   logic [1:0] zg [6] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h2, 2'h0};
   logic [1:0] zc [6] = '{2'h0, 2'h0, 2'h3, 2'h1, 2'h0, 2'h0};
   int zf [6] = '{1, 6, 1, 1, 1, 6};
   logic [7:0] ze [6] = '{8'h01, 8'h02, 8'h02, 8'h02, 8'h00, 8'h00};
   int num_errors = 0;
   int n_tests = 0;

   tfl_tx_framer u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .payload_byte_i(payload_byte_i),
      .channel_zero_suppress_select_i(channel_zero_suppress_select_i),
      .fdl_bit_i(fdl_bit_i), .chan_index_o(chan_index_o), .fdl_take_o(fdl_take_o),
      .line_bit_o(line_bit_o), .fbit_slot_o(fbit_slot_o),
      .superframe_start_o(superframe_start_o));
   tfl_line_side_model u_line (.clk_i(clk_i), .pay_i(pay), .zcs_i(channel_zero_suppress_select),
      .fdl_take_i(fdl_take_o), .payload_byte_o(payload_byte_i),
      .zcs_o(channel_zero_suppress_select_i), .fdl_bit_o(fdl_bit_i));

   initial begin
      forever #20 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr

   // A read right after a write goes out at once, so the pair is back to back.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      if (!reg_wr_i)
         @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_i);
      chk("register read", exp, reg_rdata_o);
      @(posedge clk_i);
   endtask : rd

   task automatic grab(input int k);
      int n = 0;
      if (k > 0) begin
         repeat (2) @(negedge clk_i);
         while (superframe_start_o !== 1'b1 && n < 6000) begin
            @(negedge clk_i);
            n++;
         end
         if (n == 6000)
            chk("superframe wait", 1, 0);
         repeat ((k - 1) * 193) @(negedge clk_i);
      end
      for (int i = 0; i < 193; i++) begin
         fr[i] = line_bit_o;
         @(negedge clk_i);
      end
   endtask : grab

   function automatic logic [7:0] cb(input int c);
      for (int i = 0; i < 8; i++)
         cb[7 - i] = fr[1 + 8 * c + i];
   endfunction : cb

   function automatic logic rot_ok(input int b, input int n, input int len, input logic [7:0] code);
      logic ok;
      rot_ok = 0;
      for (int r = 0; r < len; r++) begin
         ok = 1;
         for (int i = 0; i < n; i++)
            if (fr[b + i] !== code[7 - (i + r) % len])
               ok = 0;
         rot_ok |= ok;
      end
   endfunction : rot_ok

   task automatic dl_chk(input logic [7:0] c, input logic [15:0] exp);
      logic [15:0] dl;
      logic [31:0] tmp;
      logic hit = 0;
      wr(`TFL_ADDR_CFG, c);
      wr(`TFL_ADDR_ALARM, 8'h20);
      grab(1);
      dl = {15'h0000, fr[0]};
      for (int f = 2; f <= 32; f++) begin
         if (f % 2 == 1)
            dl = {dl[14:0], line_bit_o};
         repeat (193) @(negedge clk_i);
      end
      for (int r = 0; r < 16; r++) begin
         tmp = {dl, dl} >> r;
         if (tmp[15:0] == exp)
            hit = 1;
      end
      chk("data link yellow", 1, hit);
   endtask : dl_chk

   task automatic crc_chk(input logic [7:0] c);
      logic [5:0] r = 6'h00;
      logic [5:0] fas = 6'h00;
      logic [11:0] dl = 12'h000;
      logic b;
      wr(`TFL_ADDR_CFG, c);
      wr(`TFL_ADDR_ALARM, 8'h00);
      grab(1);
      for (int i = 0; i < 4632; i++) begin
         b = (i < 193) ? fr[i] : line_bit_o;
         if (i % 386 == 0)
            dl = {dl[10:0], b};
         if (i % 772 == 579)
            fas = {fas[4:0], b};
         if (i % 193 == 0 && !c[`TFL_CFG_CRC_BIT])
            b = 1'b1;
         r = {r[4:0], 1'b0} ^ ((b ^ r[5]) ? `TFL_CRC_POLY : 6'h00);
         if (i >= 193)
            @(negedge clk_i);
      end
      for (int q = 0; q < 6; q++) begin
         repeat ((q == 0) ? 193 : 772) @(negedge clk_i);
         chk("frame check bit", r[5 - q], line_bit_o);
      end
      chk("alignment pattern", `TFL_ESF_FAS, fas);
      chk("data link pass", 1, dl == 12'h555 || dl == 12'hAAA);
   endtask : crc_chk

   task automatic sf_len(input logic [7:0] c, input int exp);
      int n = 193;
      wr(`TFL_ADDR_CFG, c);
      grab(1);
      while (superframe_start_o !== 1'b1 && n < 6000) begin
         @(negedge clk_i);
         n++;
      end
      chk("superframe length", exp[15:0], n[15:0]);
   endtask : sf_len

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(8'h44 + i[7:0], 8'h00);
         wr(8'h44 + i[7:0], 8'hFF);
         rd(8'h44 + i[7:0], msk[i]);
         wr(8'h44 + i[7:0], 8'h00);
      end
      wr(`TFL_ADDR_STATUS, 8'hFF);
      wr(`TFL_ADDR_ALARM, 8'h20);
      rd(`TFL_ADDR_STATUS, 8'h40);
      wr(`TFL_ADDR_ALARM, 8'h00);
      rd(8'h50, 8'h00);
      @(posedge clk_i);
      ce_i <= 1'b0;
      wr(`TFL_ADDR_CFG, 8'h10);
      repeat (3) @(posedge clk_i);
      ce_i <= 1'b1;
      rd(`TFL_ADDR_CFG, 8'h00);
      sf_len(8'h00, 2316);
      sf_len(8'h10, 4632);
      for (int i = 0; i < 6; i++) begin
         wr(`TFL_ADDR_CFG, {6'h00, zg[i]});
         channel_zero_suppress_select <= zc[i];
         grab(zf[i]);
         chk("suppressed first channel", ze[i], cb(0));
         chk("suppressed last channel", ze[i], cb(23));
      end
      wr(`TFL_ADDR_CFG, 8'h00);
      pay <= 8'hFF;
      channel_zero_suppress_select <= 2'h0;
      wr(`TFL_ADDR_ALARM, 8'h20);
      grab(1);
      chk("yellow channel byte", 8'hBF, cb(5));
      wr(`TFL_ADDR_ALARM, 8'h00);
      grab(1);
      chk("plain channel byte", 8'hFF, cb(5));
      wr(`TFL_ADDR_CFG, 8'h20);
      wr(`TFL_ADDR_ALARM, 8'h20);
      grab(12);
      chk("twelfth framing bit yellow", 1, fr[0]);
      wr(`TFL_ADDR_ALARM, 8'h00);
      grab(12);
      chk("twelfth framing bit plain", 0, fr[0]);
      dl_chk(8'h10, 16'hFF00);
      dl_chk(8'h30, 16'hFFFF);
      crc_chk(8'h50);
      wr(`TFL_ADDR_ALARM, 8'h00);
      wr(`TFL_ADDR_CFG, 8'h00);
      wr(`TFL_ADDR_LB_CODE, 8'hB2);
      for (int l = 0; l < 4; l++) begin
         wr(`TFL_ADDR_LB_CTL, {6'h20, l[1:0]});
         grab(1);
         chk("framed code", 1, rot_ok(1, 192, 5 + l, 8'hB2));
         chk("framing bit kept", 1, fr[0]);
      end
      wr(`TFL_ADDR_LB_CTL, 8'hC3);
      repeat (400) @(negedge clk_i);
      grab(-1);
      chk("unframed code", 1, rot_ok(0, 193, 8, 8'hB2));
      wr(`TFL_ADDR_LB_CTL, 8'h00);
      grab(1);
      chk("traffic after code", 8'hFF, cb(9));
      summarize();
   end

   // The tests need at most about 83300 cycles; the margin covers slow frame alignment.
   initial begin
      repeat (96000) @(posedge clk_i);
      num_errors++;
      summarize();
   end
endmodule : tfl_tx_framer_tb_top
